// File: include/fer_pkg.sv
// Purpose: Shared constants and types of the exception reporting unit
// Assumes: 32-bit APB register bus, 80-bit extended operands
// Notes: Status and control words keep the classic 16-bit layout
package fer_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_TAG = 12'h008;
    localparam logic [11:0] OFF_INIT = 12'h00C;
    // ==========================================================
    // Reset, initialize and write-mask values
    localparam logic [15:0] CW_RESET = 16'h037E;
    localparam logic [15:0] CW_INIT = 16'h037F;
    localparam logic [15:0] CW_WMASK = 16'h1F3F;
    localparam logic [6:0] FLAGS_RESET = 7'h01;
    localparam logic [15:0] TAG_RESET = 16'hFFFF;
    // ==========================================================
    // Field positions and encodings
    localparam int EX_IE = 0;
    localparam int EX_DE = 1;
    localparam int EX_ZE = 2;
    localparam int EX_OE = 3;
    localparam int EX_UE = 4;
    localparam int EX_PE = 5;
    localparam int SW_SF = 6;
    localparam int SW_ES = 7;
    localparam int CW_RSVD = 12;
    localparam int CW_RC_LO = 10;
    localparam int SW_C0 = 8;
    localparam int SW_C3 = 14;
    localparam logic [1:0] TAG_EMPTY = 2'h3;
    localparam logic [14:0] EXP_MAX = 15'h7FFF;
    // ==========================================================
    // Rounding modes
    localparam logic [1:0] RC_NEAR = 2'h0;
    localparam logic [1:0] RC_DOWN = 2'h1;
    localparam logic [1:0] RC_UP = 2'h2;
    // ==========================================================
    // Operation codes from the datapath
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_MUL = 4'h3,
        OP_DIV = 4'h4, OP_COMPARE = 4'h5, OP_STORE_INT = 4'h6,
        OP_STORE_BCD_POP = 4'h7, OP_LOAD_REAL = 4'h8,
        OP_EXTRACT = 4'h9, OP_SCALE = 4'hA, OP_PTAN = 4'hB,
        OP_PREM = 4'hC, OP_NOWAIT_INIT = 4'hD, OP_OTHER = 4'hE
    } fer_op_e;
    // Result the datapath must substitute
    typedef enum logic [3:0] {
        RES_NORMAL = 4'h0, RES_QNAN = 4'h1, RES_INT_INDEF = 4'h2,
        RES_BCD_INDEF = 4'h3, RES_INF = 4'h4, RES_MAXFIN = 4'h5,
        RES_DENORM = 4'h6, RES_ZERO = 4'h7, RES_NEG_INF_NEXT = 4'h8,
        RES_TAN_NANS = 4'h9, RES_TAN_ONE = 4'hA, RES_HOLD = 4'hB
    } fer_res_e;
endpackage

// File: verilog/fer_classify.sv
// Purpose: Classify one 80-bit extended operand
// Assumes: Narrow formats arrive widened, exponent zero kept for denormals
// Notes: Pseudo-NaNs, pseudo-infinities and unnormals come out as unsupported; pseudo-denormals as denormal
`timescale 1ns/1ps
module fer_classify (
    input wire logic [79:0] operand,
    output logic is_zero,
    output logic is_denorm,
    output logic is_inf,
    output logic is_qnan,
    output logic is_snan,
    output logic is_unsup
);
    // ==========================================================
    // Field decode
    wire logic [14:0] exp_f = operand[78:64];
    wire logic int_bit = operand[63];
    wire logic frac_nz = |operand[62:0];
    wire logic exp_zero = (exp_f == 15'h0000);
    wire logic exp_top = (exp_f == fer_pkg::EXP_MAX);

    // Missing integer bit above exponent zero is never valid data
    assign is_unsup = ~exp_zero & ~int_bit;
    assign is_zero = exp_zero & ~int_bit & ~frac_nz;
    assign is_denorm = exp_zero & (int_bit | frac_nz);
    assign is_inf = exp_top & int_bit & ~frac_nz;
    assign is_qnan = exp_top & int_bit & operand[62];
    assign is_snan = exp_top & int_bit & ~operand[62] & frac_nz;
endmodule

// File: verilog/fer_exception_unit.sv
// Purpose: Exception detection, flags, default results and fault pin
// Assumes: Datapath presents one operation per op_valid pulse
// Notes: Result exceptions come from the datapath as raw conditions
// What the document requires
// RULE1: Six exceptions in fixed precedence, each with its own control mask.
// RULE2: Unmasked exception sets its flag, the summary bit and the fault pin.
// RULE3: Host faults on its next coprocessor opcode or wait after an error; the host model takes opcodes only.
// RULE4: Host keeps faulting instruction and operand addresses; the host model keeps only the opcode address.
// RULE5: Reset asserts fault pin: invalid flag and summary set, invalid mask clear.
// RULE6: No-wait initialize releases the fault pin.
// RULE7: Control bit 12 is reserved, cleared by reset or init, writable.
// RULE8: Condition codes clear on reset, init and incomplete partial remainder.
// RULE9: Signaling NaN, unsupported, indeterminate or stack errors are invalid.
// RULE10: Denormal operand raised; masked means normalize and continue.
// RULE11: Finite nonzero over zero raises zero divide; masked gives infinity.
// RULE12: Masked overflow gives largest finite or infinity per rounding mode.
// RULE13: Masked underflow flags only with lost accuracy; result denormal or zero.
// RULE14: Inexact raised on unrepresentable result; rounding continues.
// RULE15: Pseudo encodings and unnormals are unsupported formats; pseudo-denormals are classed as denormal here.
// RULE16: Extract of zero raises zero divide, negative infinity in next register.
// RULE17: Only signaling NaNs trap, except compare and integer or BCD stores.
// RULE18: Extended load never denormal; narrow loads flag denormal and sNaN.
// RULE19: Scale by infinity: zero invalid, else signed zero or infinity.
// RULE20: Unmasked massive overflow or underflow gives signed infinity or zero.
// RULE21: Tangent stack overflow masked gives two NaNs; otherwise 1.0 on top.
// RULE22: Tag writes other than empty must match register contents.
// RULE23: Control bits 5 to 0 mask the six exceptions.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module fer_exception_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [79:0] op_a,
    input wire logic [79:0] op_b,
    input wire logic ld_extended,
    input wire logic stack_over,
    input wire logic stack_under,
    input wire logic res_overflow,
    input wire logic res_tiny,
    input wire logic res_loss,
    input wire logic res_inexact,
    input wire logic res_massive,
    input wire logic res_sign,
    input wire logic prem_incomplete,
    input wire logic cc_load,
    input wire logic [3:0] cc_in,
    input wire logic [15:0] tag_actual,
    output logic error_n,
    output logic exc_valid,
    output logic [5:0] exc_raised,
    output logic [3:0] res_sel,
    output logic res_sign_out,
    output logic [15:0] ctrl_word
);
    // ==========================================================
    // State
    logic [15:0] cw_r, cw_nxt;
    logic [6:0] flags_r, flags_nxt;
    logic es_r, es_nxt;
    logic [3:0] cc_r, cc_nxt;
    logic [7:0] empty_r;
    logic [31:0] rdata_r;
    logic exc_valid_r;
    logic [5:0] raised_r;
    logic [3:0] res_sel_r;
    logic res_sign_r;

    // ==========================================================
    // Operand classification
    logic a_zero, a_den, a_inf, a_qnan, a_snan, a_unsup;
    logic b_zero, b_den, b_inf, b_qnan, b_snan, b_unsup;

    fer_classify u_cls_a (
        .operand(op_a),
        .is_zero(a_zero),
        .is_denorm(a_den),
        .is_inf(a_inf),
        .is_qnan(a_qnan),
        .is_snan(a_snan),
        .is_unsup(a_unsup)
    );

    fer_classify u_cls_b (
        .operand(op_b),
        .is_zero(b_zero),
        .is_denorm(b_den),
        .is_inf(b_inf),
        .is_qnan(b_qnan),
        .is_snan(b_snan),
        .is_unsup(b_unsup)
    );

    // ==========================================================
    // Instruction decode
    wire logic is_add = (op_code == fer_pkg::OP_ADD);
    wire logic is_sub = (op_code == fer_pkg::OP_SUB);
    wire logic is_mul = (op_code == fer_pkg::OP_MUL);
    wire logic is_div = (op_code == fer_pkg::OP_DIV);
    wire logic is_cmp = (op_code == fer_pkg::OP_COMPARE);
    wire logic is_sti = (op_code == fer_pkg::OP_STORE_INT);
    wire logic is_stb = (op_code == fer_pkg::OP_STORE_BCD_POP);
    wire logic is_ld = (op_code == fer_pkg::OP_LOAD_REAL);
    wire logic is_xtr = (op_code == fer_pkg::OP_EXTRACT);
    wire logic is_scl = (op_code == fer_pkg::OP_SCALE);
    wire logic is_tan = (op_code == fer_pkg::OP_PTAN);
    wire logic is_prem = (op_code == fer_pkg::OP_PREM);
    wire logic op_init = op_valid & (op_code == fer_pkg::OP_NOWAIT_INIT);
    // Second operand only matters for two-operand instructions
    wire logic use_b = is_add | is_sub | is_mul | is_div | is_cmp | is_scl;
    wire logic ld_ext = is_ld & ld_extended;
    wire logic sa = op_a[79];
    wire logic sb = op_b[79];

    // ==========================================================
    // APB decode; zero wait states, unmapped offsets answer with error
    wire logic hit_ctrl = (paddr == fer_pkg::OFF_CTRL);
    wire logic hit_stat = (paddr == fer_pkg::OFF_STATUS);
    wire logic hit_tag = (paddr == fer_pkg::OFF_TAG);
    wire logic hit_init = (paddr == fer_pkg::OFF_INIT);
    wire logic hit_any = hit_ctrl | hit_stat | hit_tag | hit_init;
    wire logic acc = psel & penable;
    wire logic wr = acc & pwrite & hit_any;
    wire logic setup_rd = psel & ~penable & ~pwrite;
    wire logic sw_init = wr & hit_init & pwdata[0];
    wire logic init_go = op_init | sw_init;
    wire logic [6:0] w1c = (wr & hit_stat) ? pwdata[6:0] : 7'h00;

    assign pready = 1'b1;
    assign pslverr = acc & ~hit_any;

    // ==========================================================
    // Raw conditions
    wire logic snan_any = a_snan | (use_b & b_snan);
    wire logic qnan_any = a_qnan | (use_b & b_qnan);
    wire logic unsup_any = a_unsup | (use_b & b_unsup); // RULE15
    wire logic den_any = a_den | (use_b & b_den);
    wire logic nan_a = a_qnan | a_snan;
    // Quiet NaNs trap only where an ordered or integer result is needed
    wire logic quiet_trap = qnan_any & (is_cmp | is_sti | is_stb); // RULE17
    wire logic both_inf = a_inf & b_inf;
    wire logic indet = (is_mul & ((a_zero & b_inf) | (a_inf & b_zero)))
        | (is_div & ((a_zero & b_zero) | both_inf))
        | (is_add & both_inf & (sa != sb))
        | (is_sub & both_inf & (sa == sb))
        | (is_scl & a_zero & b_inf); // RULE19
    wire logic stack_err = stack_over | stack_under;
    // Extended loads only move bits, so no operand checks apply
    wire logic raw_ie = stack_err
        | (~ld_ext & (snan_any | unsup_any | quiet_trap | indet)); // RULE9 RULE18
    wire logic raw_de = den_any & ~ld_ext; // RULE10 RULE18
    wire logic raw_ze = (is_div & b_zero & ~a_zero & ~a_inf & ~nan_a)
        | (is_xtr & a_zero); // RULE11 RULE16

    // ==========================================================
    // Precedence: invalid blocks all; unmasked denormal and zero
    // divide stop the operation before any result is formed
    wire logic [5:0] mask = cw_r[5:0];
    wire logic ex_ie = raw_ie; // RULE1
    wire logic ex_de = ~ex_ie & raw_de;
    wire logic de_stop = ex_de & ~mask[fer_pkg::EX_DE];
    wire logic ex_ze = ~ex_ie & ~de_stop & raw_ze;
    wire logic go_res = ~ex_ie & ~de_stop & ~ex_ze;
    wire logic ex_oe = go_res & res_overflow;
    wire logic ex_ue = go_res & res_tiny
        & (~mask[fer_pkg::EX_UE] | res_loss); // RULE13
    wire logic ex_pe = go_res & res_inexact; // RULE14
    wire logic [5:0] raised = {ex_pe, ex_ue, ex_oe, ex_ze, ex_de, ex_ie};
    wire logic [5:0] ev = op_valid ? raised : 6'h00;

    // ==========================================================
    // Default result selection
    wire logic [1:0] rc = cw_r[fer_pkg::CW_RC_LO +: 2];
    // Round to nearest or toward the sign's infinity gives infinity, otherwise max
    wire logic ovf_inf = (rc == fer_pkg::RC_NEAR)
        | ((rc == fer_pkg::RC_UP) & ~res_sign)
        | ((rc == fer_pkg::RC_DOWN) & res_sign); // RULE12
    wire logic m_ie = mask[fer_pkg::EX_IE];
    wire logic m_ze = mask[fer_pkg::EX_ZE];
    wire logic m_oe = mask[fer_pkg::EX_OE];
    wire logic m_ue = mask[fer_pkg::EX_UE];
    wire logic scl_inf = is_scl & b_inf & ~a_zero & ~nan_a & ~a_unsup;
    wire logic [3:0] ie_res = ~m_ie ? fer_pkg::RES_HOLD
        : is_sti ? fer_pkg::RES_INT_INDEF
        : is_stb ? fer_pkg::RES_BCD_INDEF
        : (is_tan & stack_over) ? fer_pkg::RES_TAN_NANS // RULE21
        : fer_pkg::RES_QNAN; // RULE9
    wire logic [3:0] ov_res = m_oe ? (ovf_inf ? fer_pkg::RES_INF : fer_pkg::RES_MAXFIN)
        : (res_massive ? fer_pkg::RES_INF : fer_pkg::RES_HOLD); // RULE12 RULE20
    wire logic [3:0] un_res = m_ue ? fer_pkg::RES_DENORM
        : (res_massive ? fer_pkg::RES_ZERO : fer_pkg::RES_HOLD); // RULE13 RULE20
    wire logic [3:0] sel = ex_ie ? ie_res
        : de_stop ? fer_pkg::RES_HOLD
        : (ex_ze & is_xtr) ? fer_pkg::RES_NEG_INF_NEXT // RULE16
        : ex_ze ? (m_ze ? fer_pkg::RES_INF : fer_pkg::RES_HOLD) // RULE11
        : scl_inf ? (sb ? fer_pkg::RES_ZERO : fer_pkg::RES_INF) // RULE19
        : ex_oe ? ov_res
        : ex_ue ? un_res
        : is_tan ? fer_pkg::RES_TAN_ONE // RULE21
        : fer_pkg::RES_NORMAL;
    wire logic sign_sel = scl_inf ? sa : res_sign;

    // ==========================================================
    // Next state of words; a new event wins over a status clear, initialize wins over both
    always_comb begin
        flags_nxt = flags_r & ~w1c;
        flags_nxt[5:0] = flags_nxt[5:0] | ev; // RULE2
        flags_nxt[fer_pkg::SW_SF] = flags_nxt[fer_pkg::SW_SF]
            | (op_valid & ex_ie & stack_err); // RULE9
        cw_nxt = (wr & hit_ctrl) ? (pwdata[15:0] & fer_pkg::CW_WMASK) : cw_r; // RULE7
        cc_nxt = cc_load ? cc_in : cc_r;
        if (op_valid & is_prem & prem_incomplete) begin
            cc_nxt = 4'h0; // RULE8
        end
        if (init_go) begin
            flags_nxt = 7'h00; // RULE6
            cw_nxt = fer_pkg::CW_INIT; // RULE7
            cc_nxt = 4'h0; // RULE8
        end
        es_nxt = |(flags_nxt[5:0] & ~cw_nxt[5:0]); // RULE2 RULE23
    end

    // Architectural words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cw_r <= fer_pkg::CW_RESET; // RULE5
            flags_r <= fer_pkg::FLAGS_RESET; // RULE5
            es_r <= 1'b1; // RULE5
            cc_r <= 4'h0; // RULE8
        end else begin
            cw_r <= cw_nxt;
            flags_r <= flags_nxt;
            es_r <= es_nxt;
            cc_r <= cc_nxt;
        end
    end

    // ==========================================================
    // Tag entries: software may mark empty, or restate the live tag
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_tag
            wire logic [1:0] wtag = pwdata[2*gi +: 2];
            wire logic [1:0] live = tag_actual[2*gi +: 2];
            wire logic tw = wr & hit_tag;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    empty_r[gi] <= 1'b1;
                end else if (init_go) begin
                    empty_r[gi] <= 1'b1;
                end else if (tw & (wtag == fer_pkg::TAG_EMPTY)) begin
                    empty_r[gi] <= 1'b1;
                end else if (tw & (wtag == live)) begin
                    empty_r[gi] <= 1'b0; // RULE22
                end
            end
        end
    endgenerate

    logic [15:0] tag_view;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            tag_view[2*i +: 2] = empty_r[i] ? fer_pkg::TAG_EMPTY : tag_actual[2*i +: 2];
        end
    end

    // ==========================================================
    // Read data captured in the setup phase
    // Bit 15 spare, C3 at 14, 13:11 spare, C2..C0 at 10:8
    wire logic [15:0] stat_view = {1'b0, cc_r[3], 3'h0, cc_r[2:0], es_r, flags_r};
    wire logic [15:0] rd_mux = hit_ctrl ? cw_r
        : hit_stat ? stat_view
        : hit_tag ? tag_view
        : 16'h0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (setup_rd) begin
            rdata_r <= {16'h0000, rd_mux};
        end
    end

    // ==========================================================
    // Per-operation report toward the datapath
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exc_valid_r <= 1'b0;
            raised_r <= 6'h00;
            res_sel_r <= fer_pkg::RES_NORMAL;
            res_sign_r <= 1'b0;
        end else begin
            exc_valid_r <= op_valid & ~op_init;
            raised_r <= ev;
            res_sel_r <= op_valid ? sel : fer_pkg::RES_NORMAL;
            res_sign_r <= sign_sel;
        end
    end

    // Fault pin is low while any unmasked flag stands
    assign error_n = ~es_r; // RULE2 RULE3
    assign prdata = rdata_r;
    assign exc_valid = exc_valid_r;
    assign exc_raised = raised_r;
    assign res_sel = res_sel_r;
    assign res_sign_out = res_sign_r;
    assign ctrl_word = cw_r;

    // ==========================================================
    // Checks
    a_fault_unmasked: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        (op_valid && !op_init && ((raised & ~mask) != 6'h00)) |=> !error_n)
        else $error("unmasked exception did not assert fault pin");
    a_init_release: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        op_init |=> (error_n && flags_r == 7'h00))
        else $error("initialize did not release fault pin");
    a_init_rsvd_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        init_go |=> (cw_r[fer_pkg::CW_RSVD] == 1'b0 && cw_r == fer_pkg::CW_INIT))
        else $error("initialize left control word wrong");
    a_cc_cleared: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (op_valid && is_prem && prem_incomplete && !cc_load) |=> cc_r == 4'h0)
        else $error("condition codes not cleared");
    a_zd_masked_inf: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        (op_valid && is_div && !ex_ie && !de_stop && raw_ze && m_ze)
        |=> (raised_r[fer_pkg::EX_ZE] && res_sel_r == fer_pkg::RES_INF))
        else $error("masked zero divide gave wrong result");
    a_ext_load_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
        (op_valid && ld_ext && !stack_err) |=> raised_r[1:0] == 2'h0)
        else $error("extended load raised operand exception");
    a_snan_invalid: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
        (op_valid && a_snan && !ld_ext && !op_init)
        |=> (raised_r[fer_pkg::EX_IE] && flags_r[fer_pkg::EX_IE]))
        else $error("signaling NaN not flagged invalid");
    a_prec_order: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        exc_valid_r && raised_r[fer_pkg::EX_IE] |-> raised_r[5:1] == 5'h00)
        else $error("invalid operation did not take precedence");
    a_ovf_rounding: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        (op_valid && ex_oe && m_oe && rc == fer_pkg::RC_NEAR)
        |=> res_sel_r == fer_pkg::RES_INF)
        else $error("masked overflow ignored rounding mode");
    a_tag_guard: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
        (wr && hit_tag && !init_go && pwdata[1:0] != fer_pkg::TAG_EMPTY
            && pwdata[1:0] != tag_actual[1:0]) |=> $stable(empty_r[0]))
        else $error("tag write disagreeing with contents was taken");
endmodule

// File: dv/fer_host_model.sv
// Purpose: Host processor stand-in that reacts to the fault pin
// Assumes: One coprocessor opcode attempt per esc_try pulse
// Notes: Only the fault side of the host is modelled, no handler code
`timescale 1ns/1ps
// ==========================================================
// Host model
module fer_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic error_n,
    input wire logic esc_try,
    input wire logic [31:0] esc_addr,
    output logic fault,
    output logic [31:0] fault_addr
);
    // Fault on the next opcode while the pin is low; keep the address for the handler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault <= 1'b0;
            fault_addr <= 32'h0000_0000;
        end else begin
            fault <= esc_try & ~error_n;
            if (esc_try & ~error_n) fault_addr <= esc_addr;
        end
    end
endmodule

// File: dv/fer_exception_unit_tb.sv
// Purpose: Self-checking bench of the exception reporting unit
// Assumes: Zero-wait APB slave, one-cycle operation answer
// Notes: Stack underflow input stays constant
`timescale 1ns/1ps
module fer_exception_unit_tb;
    // ==========================================================
    // Signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic op_valid = 1'b0;
    logic cc_load = 1'b0;
    logic esc_try = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, esc_addr = 32'h0, prdata, rd, fault_addr;
    logic [3:0] op_code = 4'h0, cc_in = 4'h0, res_sel;
    logic [79:0] op_a = 80'h0, op_b = 80'h0;
    logic [7:0] fl = 8'h00; // ld_ext, st_over, ovf, prem_inc, inexact, sign, tiny, loss
    logic mass = 1'b0;
    logic [15:0] tag_live = 16'hFFFF;
    logic pready, pslverr, se, error_n, exc_valid, res_sign_out, fault;
    logic [5:0] exc_raised;
    logic [15:0] ctrl_word;
    int err_total = 0, cmp_count = 0, cycles = 0;
    localparam logic [79:0] ONE = 80'h3FFF_8000_0000_0000_0000;
    localparam logic [79:0] SNAN = 80'h7FFF_A000_0000_0000_0000;
    localparam logic [79:0] QNAN = 80'h7FFF_C000_0000_0000_0000;
    localparam logic [79:0] DEN = 80'h0000_4000_0000_0000_0000;

    fer_exception_unit i_fer_exception_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
        .op_a(op_a), .op_b(op_b), .ld_extended(fl[7]), .stack_over(fl[6]),
        .stack_under(1'b0), .res_overflow(fl[5]), .res_tiny(fl[1]), .res_loss(fl[0]),
        .res_inexact(fl[3]), .res_massive(mass), .res_sign(fl[2]),
        .prem_incomplete(fl[4]), .cc_load(cc_load), .cc_in(cc_in), .tag_actual(tag_live),
        .error_n(error_n), .exc_valid(exc_valid), .exc_raised(exc_raised),
        .res_sel(res_sel), .res_sign_out(res_sign_out), .ctrl_word(ctrl_word));
    fer_host_model i_fer_host_model (.pclk(pclk), .presetn(presetn), .error_n(error_n),
        .esc_try(esc_try), .esc_addr(esc_addr), .fault(fault), .fault_addr(fault_addr));

    // ==========================================================
    // Clock and hang guard
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            conclude();
        end
    end

    // ==========================================================
    // Tasks
    // Wide enough for a flag concatenated with a full data word
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Setup then access phase; request held until pready is seen high
    task automatic apb(logic wr, logic [11:0] ad, logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    // One operation pulse; answer settled one edge later
    task automatic op(logic [3:0] c, logic [79:0] a, logic [79:0] b, logic [7:0] f);
        @(posedge pclk);
        op_valid <= 1'b1;
        op_code <= c;
        op_a <= a;
        op_b <= b;
        fl <= f;
        @(posedge pclk);
        op_valid <= 1'b0;
        fl <= 8'h00;
        #1;
    endtask
    task automatic coproc_opcode_instr(logic [31:0] ad);
        @(posedge pclk);
        esc_try <= 1'b1;
        esc_addr <= ad;
        @(posedge pclk);
        esc_try <= 1'b0;
        #1;
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // Main sequence; status is cleared before the precedence cases and again before the masked cases
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("pin_rst", error_n, 0);
        apb(0, fer_pkg::OFF_CTRL, 0);
        chk("ctrl_rst", rd, fer_pkg::CW_RESET);
        apb(0, fer_pkg::OFF_STATUS, 0);
        chk("stat_rst", rd, 32'h0081);
        op(fer_pkg::OP_NOWAIT_INIT, 0, 0, 0);
        chk("pin_init", error_n, 1);
        apb(0, fer_pkg::OFF_STATUS, 0);
        chk("stat_init", rd, 32'h0000);
        coproc_opcode_instr(32'h0000_1230);
        chk("no_fault", fault, 0);
        apb(1, fer_pkg::OFF_CTRL, 32'h1000);
        apb(0, fer_pkg::OFF_CTRL, 0);
        chk("bit12", rd, 32'h1000);
        op(fer_pkg::OP_DIV, ONE, 0, 0);
        chk("zdiv", {exc_raised, res_sel, error_n}, {6'h04, fer_pkg::RES_HOLD, 1'b0});
        apb(0, fer_pkg::OFF_STATUS, 0);
        chk("stat_zd", rd, 32'h0084);
        coproc_opcode_instr(32'h0000_4560);
        chk("fault", {fault, fault_addr}, {1'b1, 32'h0000_4560});
        apb(1, fer_pkg::OFF_STATUS, 32'h7F);
        op(fer_pkg::OP_DIV, SNAN, 0, 0);
        chk("prec", exc_raised, 6'h01);
        op(fer_pkg::OP_ADD, QNAN, ONE, 0);
        chk("qnan_add", exc_raised, 6'h00);
        op(fer_pkg::OP_COMPARE, QNAN, ONE, 0);
        chk("qnan_cmp", exc_raised, 6'h01);
        op(fer_pkg::OP_EXTRACT, 0, 0, 0);
        chk("xtr", {exc_raised, res_sel}, {6'h04, fer_pkg::RES_NEG_INF_NEXT});
        op(fer_pkg::OP_ADD, ONE, ONE, 8'h08);
        chk("inexact", exc_raised, 6'h20);
        apb(1, fer_pkg::OFF_STATUS, 32'h7F);
        apb(1, fer_pkg::OFF_CTRL, 32'h003F);
        op(fer_pkg::OP_DIV, ONE, 0, 0);
        chk("zd_mask", {res_sel, error_n}, {fer_pkg::RES_INF, 1'b1});
        op(fer_pkg::OP_ADD, ONE, ONE, 8'h20);
        chk("ovf_near", res_sel, fer_pkg::RES_INF);
        op(fer_pkg::OP_MUL, ONE, ONE, 8'h02);
        chk("uf_noloss", exc_raised[4], 0);
        op(fer_pkg::OP_LOAD_REAL, DEN, 0, 8'h80);
        chk("ld_ext", exc_raised, 6'h00);
        op(fer_pkg::OP_LOAD_REAL, DEN, 0, 8'h00);
        chk("ld_narrow", exc_raised, 6'h02);
        op(fer_pkg::OP_PTAN, ONE, 0, 8'h40);
        chk("ptan", res_sel, fer_pkg::RES_TAN_NANS);
        apb(0, fer_pkg::OFF_STATUS, 0);
        chk("sf", rd & 32'h40, 32'h40);
        // Load all condition codes so the clear below is visible
        @(posedge pclk);
        cc_load <= 1'b1;
        cc_in <= 4'hF;
        @(posedge pclk);
        cc_load <= 1'b0;
        apb(0, fer_pkg::OFF_STATUS, 0);
        chk("cc_set", rd & 32'h4700, 32'h4700);
        op(fer_pkg::OP_PREM, ONE, ONE, 8'h10);
        apb(0, fer_pkg::OFF_STATUS, 0);
        chk("cc_prem", rd & 32'h4700, 32'h0);
        // Live tags all valid: a disagreeing write is refused, a matching one taken
        tag_live <= 16'h0000;
        apb(1, fer_pkg::OFF_TAG, 32'h5555);
        apb(0, fer_pkg::OFF_TAG, 0);
        chk("tag_refuse", rd, 32'hFFFF);
        apb(1, fer_pkg::OFF_TAG, 32'h0000);
        apb(0, fer_pkg::OFF_TAG, 0);
        chk("tag_match", rd, 32'h0000);
        // Overflow unmasked with a massive result gives signed infinity
        apb(1, fer_pkg::OFF_CTRL, 32'h0037);
        mass <= 1'b1;
        op(fer_pkg::OP_ADD, ONE, ONE, 8'h24);
        mass <= 1'b0;
        chk("massive", {exc_valid, exc_raised, res_sel}, {1'b1, 6'h08, fer_pkg::RES_INF});
        chk("ctrl_sign", {ctrl_word, res_sign_out}, {16'h0037, 1'b1});
        // Second reset in mid-run brings the fault pin back
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("pin_rst2", {error_n, ctrl_word}, {1'b0, fer_pkg::CW_RESET});
        apb(0, 12'h010, 0);
        chk("unmapped", {se, rd}, {1'b1, 32'h0});
        conclude();
    end
endmodule
